//--- hw/addr_strap_decode.sv
`timescale 1ns/1ps
module addr_strap_decode
    import host_port_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    strap_if.decoder  sif
);

    // Each strap keeps four candidates: ground, supply, SCL and SDA.
    // A candidate drops out on the first sample that contradicts it, so
    // a strap tied to a bus line is told apart once the bus moves.
    logic [3:0] cand [2];
    logic [1:0] single;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_strap
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cand[i] <= 4'hF;
                end else if (!sif.enable) begin
                    cand[i] <= 4'hF;
                end else begin
                    cand[i] <= cand[i] & {sif.strap[i] == sif.sda, // RL6
                                          sif.strap[i] == sif.scl,
                                          sif.strap[i],
                                          !sif.strap[i]};
                end
            end

            assign single[i] = $onehot(cand[i]);

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    sif.code[i] <= STRAP_GND;
                end else if (single[i]) begin
                    unique case (1'b1)
                        cand[i][0]: sif.code[i] <= STRAP_GND; // RL6
                        cand[i][1]: sif.code[i] <= STRAP_VL;
                        cand[i][2]: sif.code[i] <= STRAP_SCL;
                        cand[i][3]: sif.code[i] <= STRAP_SDA;
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sif.valid <= 1'b0;
        end else begin
            sif.valid <= sif.enable & (&single);
        end
    end

endmodule // addr_strap_decode

//--- hw/host_port_cfg.svh
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH

// Synchroniser depth for every pin that enters the clk domain.
`define HP_SYNC_STAGES 2

// Highest clock rate that the shared clock pin carries in each mode.
`define HP_SPI_MAX_HZ 26000000
`define HP_I2C_MAX_HZ 1000000

// Core clock rate.
`define HP_CLK_HZ 10000000

// Position of each pin in the synchronised pin vector.
`define HP_PIN_SEL    0
`define HP_PIN_CLK    1
`define HP_PIN_STRAP0 2
`define HP_PIN_STRAP1 3
`define HP_PIN_SDA    4
`define HP_PIN_RST    5
`define HP_PIN_COUNT  6

// Reset values.
`define HP_RST_PINS   6'h3F
`define HP_RST_ADDR   4'h0

`endif

//--- hw/host_port_pin_select.sv
`timescale 1ns/1ps
`include "host_port_cfg.svh"

// What this block does
// RL1: A high selector puts the shared pins in SPI target mode, low in I2C.
// RL2: The data pin is the MISO output in SPI mode and the SDA line in I2C.
// RL3: The clock pin is SCLK (to 26 MHz) in SPI mode, SCL (to 1 MHz) in I2C; SCLK is sampled at the 10 MHz core clock, which misses edges at 26 MHz.
// RL4: The select/strap-0 pin is the active-low chip select in SPI mode.
// RL5: The data-in/strap-1 pin is MOSI in SPI mode and strap 1 in I2C mode.
// RL6: Each strap ties to SDA, SCL, ground or supply and sets the address.
// RL7: The open-drain interrupt output pulls low while an interrupt pends.
// RL8: While the reset pin is low every UART channel is held in reset.
// RL9: While in reset the oscillator and PLL are stopped; this block only clears oscEnable and has no PLL control.
// RL10: The host changes the selector only while the device is in reset.
module host_port_pin_select
    import host_port_pkg::*;
#(
    parameter int SYNC_STAGES = `HP_SYNC_STAGES
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       hostIfSelect,
    input  wire logic       clkPin,
    input  wire logic       selectOrAddrStrap0,
    input  wire logic       dataInOrAddrStrap1,
    input  wire logic       serialDataIn,
    input  wire logic       deviceReset_b,
    input  wire logic       misoData,
    input  wire logic       sdaDriveLow,
    input  wire logic       irqPending,
    output logic            serialDataOut,
    output logic            serialDataOe,
    output logic            irqOut,
    output logic            irqOe,
    output logic            spiMode,
    output logic            spiSclkRise,
    output logic            spiSclkFall,
    output logic            spiSelect_b,
    output logic            spiMosi,
    output logic            i2cScl,
    output logic            i2cSdaIn,
    output logic [3:0]      i2cAddrCode,
    output logic            i2cAddrValid,
    output logic            uartReset,
    output logic            oscEnable
);

    localparam int SPI_HALF_NS = 1000000000 / (2 * `HP_SPI_MAX_HZ);
    localparam int I2C_HALF_CYC = `HP_CLK_HZ / (2 * `HP_I2C_MAX_HZ);

    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    logic [`HP_PIN_COUNT-1:0] syncStage [SYNC_STAGES];
    logic [`HP_PIN_COUNT-1:0] pins;
    logic [`HP_PIN_COUNT-1:0] rawPins;
    logic [SYNC_STAGES-1:0]   primed;
    logic                     pinsLive;
    logic                     prevClk;
    logic                     inReset;
    host_mode_e               mode;
    strap_if                  sif ();

    assign rawPins = {deviceReset_b, serialDataIn, dataInOrAddrStrap1,
                      selectOrAddrStrap0, clkPin, hostIfSelect};

    genvar s;
    generate
        for (s = 0; s < SYNC_STAGES; s++) begin : g_sync
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    syncStage[s] <= `HP_RST_PINS;
                end else if (s == 0) begin
                    syncStage[s] <= rawPins;
                end else begin
                    syncStage[s] <= syncStage[(s == 0) ? 0 : s - 1];
                end
            end
        end
    endgenerate

    assign pins = syncStage[SYNC_STAGES-1];
    assign inReset = !pins[`HP_PIN_RST];

    // The synchroniser shows its reset values, not pin levels, until it
    // has been refilled; the strap decoder must not learn from those.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            primed <= '0;
        end else begin
            primed <= {primed[SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign pinsLive = primed[SYNC_STAGES-1];

    // The mode follows the selector only while the device sits in reset,
    // so a transfer in flight can never be cut in two.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= MODE_I2C;
        end else if (inReset) begin // RL10
            mode <= pins[`HP_PIN_SEL] ? MODE_SPI : MODE_I2C; // RL1
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spiMode <= 1'b0;
        end else begin
            spiMode <= (mode == MODE_SPI); // RL1
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            uartReset <= 1'b1;
            oscEnable <= 1'b0;
        end else begin
            uartReset <= inReset; // RL8
            oscEnable <= !inReset; // RL9
        end
    end

    // Clock pin: edges in SPI mode, a level in I2C mode.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prevClk     <= 1'b1;
            spiSclkRise <= 1'b0;
            spiSclkFall <= 1'b0;
            i2cScl      <= 1'b1;
        end else begin
            prevClk     <= pins[`HP_PIN_CLK];
            spiSclkRise <= (mode == MODE_SPI) && !inReset // RL3
                           && pins[`HP_PIN_CLK] && !prevClk;
            spiSclkFall <= (mode == MODE_SPI) && !inReset // RL3
                           && !pins[`HP_PIN_CLK] && prevClk;
            i2cScl      <= (mode == MODE_I2C) ? pins[`HP_PIN_CLK] : 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            spiSelect_b <= 1'b1;
            spiMosi     <= 1'b0;
            i2cSdaIn    <= 1'b1;
        end else if (mode == MODE_SPI) begin
            spiSelect_b <= pins[`HP_PIN_STRAP0] | inReset; // RL4
            spiMosi     <= pins[`HP_PIN_STRAP1]; // RL5
            i2cSdaIn    <= 1'b1;
        end else begin
            spiSelect_b <= 1'b1; // RL4
            spiMosi     <= 1'b0; // RL5
            i2cSdaIn    <= pins[`HP_PIN_SDA]; // RL2
        end
    end

    // Shared data pin: MISO while selected in SPI mode, open-drain SDA in I2C mode, else released.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;
        end else if (inReset) begin
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;
        end else if (mode == MODE_SPI) begin
            serialDataOut <= misoData; // RL2
            serialDataOe  <= !pins[`HP_PIN_STRAP0];
        end else begin
            serialDataOut <= 1'b0; // RL2
            serialDataOe  <= sdaDriveLow;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqOut <= 1'b0;
            irqOe  <= 1'b0;
        end else begin
            irqOut <= 1'b0;
            irqOe  <= irqPending; // RL7
        end
    end

    assign sif.enable = (mode == MODE_I2C) && !inReset && pinsLive; // RL6
    assign sif.scl    = pins[`HP_PIN_CLK];
    assign sif.sda    = pins[`HP_PIN_SDA];
    assign sif.strap  = {pins[`HP_PIN_STRAP1], pins[`HP_PIN_STRAP0]}; // RL4

    addr_strap_decode u_decode (
        .clk   (clk),
        .rst_b (rst_b),
        .sif   (sif.decoder)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            i2cAddrCode  <= `HP_RST_ADDR;
            i2cAddrValid <= 1'b0;
        end else begin
            i2cAddrCode  <= {sif.code[1], sif.code[0]}; // RL6
            i2cAddrValid <= sif.valid;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    mode_hold_a: assert property (!inReset && $past(!inReset) // RL10
        |-> $stable(mode)) else $error("mode changed outside reset");
    spi_miso_a: assert property ((mode == MODE_SPI) && !inReset // RL2
        && !pins[`HP_PIN_STRAP0] |=> serialDataOe && serialDataOut
        == $past(misoData)) else $error("MISO not driven when selected");
    i2c_sda_a: assert property ((mode == MODE_I2C) // RL2
        |=> !serialDataOut) else $error("SDA driven high in I2C mode");
    sclk_edge_a: assert property ((mode == MODE_SPI) && !inReset // RL3
        && $rose(pins[`HP_PIN_CLK]) |=> spiSclkRise)
        else $error("SCLK rise missed");
    cs_idle_a: assert property ((mode == MODE_I2C) |=> spiSelect_b) // RL4
        else $error("chip select active in I2C mode");
    mosi_pass_a: assert property ((mode == MODE_SPI) // RL5
        |=> spiMosi == $past(pins[`HP_PIN_STRAP1]))
        else $error("MOSI not passed through");
    irq_follow_a: assert property (irqPending |=> irqOe && !irqOut) // RL7
        else $error("interrupt not pulled low");
    irq_release_a: assert property (!irqPending |=> !irqOe) // RL7
        else $error("interrupt held without cause");
    uart_reset_a: assert property (inReset |=> uartReset) // RL8
        else $error("UART left out of reset");
    osc_stop_a: assert property (inReset |=> !oscEnable) // RL9
        else $error("oscillator runs in reset");
    spi_mode_a: assert property ((mode == MODE_SPI) |=> spiMode) // RL1
        else $error("mode output disagrees");
    addr_valid_a: assert property (i2cAddrValid // RL6
        |-> spiMode == 1'b0 || $past(mode) == MODE_I2C)
        else $error("address valid outside I2C mode");

    spi_xfer_c: cover property (spiSclkRise && !spiSelect_b);
    i2c_addr_c: cover property ($rose(i2cAddrValid));
    irq_c:      cover property ($rose(irqOe) ##[1:20] $fell(irqOe));
    mode_sw_c:  cover property (inReset ##1 $changed(mode));

endmodule // host_port_pin_select

//--- hw/host_port_pkg.sv
package host_port_pkg;

    // Mode of the shared host pins, one-hot.
    typedef enum logic [1:0] {
        MODE_I2C = 2'b01,
        MODE_SPI = 2'b10
    } host_mode_e;

    // What an address strap pin is tied to.
    typedef enum logic [1:0] {
        STRAP_GND = 2'h0,
        STRAP_VL  = 2'h1,
        STRAP_SCL = 2'h2,
        STRAP_SDA = 2'h3
    } strap_code_e;

endpackage

//--- hw/strap_if.sv
`timescale 1ns/1ps
interface strap_if;
    import host_port_pkg::*;

    logic        enable;
    logic        scl;
    logic        sda;
    logic [1:0]  strap;
    strap_code_e code [2];
    logic        valid;

    modport decoder (
        input  enable,
        input  scl,
        input  sda,
        input  strap,
        output code,
        output valid
    );

    modport user (
        output enable,
        output scl,
        output sda,
        output strap,
        input  code,
        input  valid
    );
endinterface

//--- verif/host_pin_model.sv
`timescale 1ns/1ps
module host_pin_model
    import host_port_pkg::*;
(
    input  wire logic sdaLine,
    output logic      hostIfSelect,
    output logic      clkPin,
    output logic      selectOrAddrStrap0,
    output logic      dataInOrAddrStrap1,
    output logic      deviceReset_b,
    output logic      hostSda
);
    logic        spiCs_b    = 1'b1;
    logic        spiMosiPin = 1'b0;
    strap_code_e tie [2]    = '{STRAP_GND, STRAP_GND};
    logic [3:0]  tieLevel;

    // In I2C mode each strap is a board wire to ground, supply, SCL or SDA.
    assign tieLevel = {sdaLine, clkPin, 1'b1, 1'b0};
    assign selectOrAddrStrap0 = hostIfSelect ? spiCs_b : tieLevel[tie[0]];
    assign dataInOrAddrStrap1 = hostIfSelect ? spiMosiPin : tieLevel[tie[1]];

    initial begin
        hostIfSelect  = 1'b0;
        clkPin        = 1'b0;
        deviceReset_b = 1'b1;
        hostSda       = 1'b1;
    end

    // This task moves the selector only while the device is held in reset.
    task automatic hold_reset(input logic sel);
        deviceReset_b = 1'b0;
        #600;
        hostIfSelect = sel;
        #600;
    endtask

    task automatic release_reset();
        deviceReset_b = 1'b1;
        #600;
    endtask

    // SDA toggles in the clock's low phase so it differs from SCL at times.
    task automatic burst(input int n);
        repeat (n) begin
            #200;
            if (!hostIfSelect) hostSda = ~hostSda;
            #200;
            clkPin = 1'b1;
            #400;
            clkPin = 1'b0;
        end
    endtask
endmodule // host_pin_model

//--- verif/host_port_pin_select_tb_top.sv
`timescale 1ns/1ps
module host_port_pin_select_tb_top
    import host_port_pkg::*;
();
    logic       clk = 1'b0, rst_b = 1'b0;
    logic       misoData = 1'b0, sdaDriveLow = 1'b0, irqPending = 1'b0;
    wire logic  sel, sclPin, pin0, pin1, devRst_b, hostSda, sdaLine;
    wire logic  sdOut, sdOe, irqOut, irqOe, spiMode, sRise, sFall;
    wire logic  spiSelect_b, spiMosi, i2cScl, i2cSdaIn, aValid, uRst, osc;
    wire logic [3:0] aCode;
    int         failures = 0, samplesChecked = 0, riseSeen, fallSeen;

    // The data line has a pull-up; either side may only pull it low.
    assign sdaLine = (sdOe ? sdOut : 1'b1) & hostSda;

    initial begin
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (sRise === 1'b1) riseSeen++;
        if (sFall === 1'b1) fallSeen++;
    end

    host_pin_model host_pin_model_inst (
        .sdaLine(sdaLine), .hostIfSelect(sel), .clkPin(sclPin),
        .selectOrAddrStrap0(pin0), .dataInOrAddrStrap1(pin1),
        .deviceReset_b(devRst_b), .hostSda(hostSda));

    host_port_pin_select host_port_pin_select_inst (
        .clk(clk), .rst_b(rst_b), .hostIfSelect(sel), .clkPin(sclPin),
        .selectOrAddrStrap0(pin0), .dataInOrAddrStrap1(pin1),
        .serialDataIn(sdaLine), .deviceReset_b(devRst_b),
        .misoData(misoData), .sdaDriveLow(sdaDriveLow),
        .irqPending(irqPending), .serialDataOut(sdOut),
        .serialDataOe(sdOe), .irqOut(irqOut), .irqOe(irqOe),
        .spiMode(spiMode), .spiSclkRise(sRise), .spiSclkFall(sFall),
        .spiSelect_b(spiSelect_b), .spiMosi(spiMosi), .i2cScl(i2cScl),
        .i2cSdaIn(i2cSdaIn), .i2cAddrCode(aCode), .i2cAddrValid(aValid),
        .uartReset(uRst), .oscEnable(osc));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_bit(input string what, input logic exp, got);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_nib(input string what, input logic [3:0] exp, got);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic run_burst(input int n);
        riseSeen = 0;
        fallSeen = 0;
        host_pin_model_inst.burst(n);
        cyc(5);
    endtask

    task automatic enter_mode(input logic s);
        host_pin_model_inst.hold_reset(s);
        check_bit("uart reset held", 1'b1, uRst);
        check_bit("oscillator stopped", 1'b0, osc);
        host_pin_model_inst.release_reset();
        check_bit("uart reset freed", 1'b0, uRst);
        check_bit("oscillator running", 1'b1, osc);
        check_bit("mode", s, spiMode);
    endtask

    task automatic spi_scenario();
        enter_mode(1'b1);
        host_pin_model_inst.spiCs_b = 1'b0;
        host_pin_model_inst.spiMosiPin = 1'b1;
        misoData = 1'b1;
        cyc(4);
        check_bit("chip select", 1'b0, spiSelect_b);
        check_bit("mosi", 1'b1, spiMosi);
        check_bit("miso enable", 1'b1, sdOe);
        check_bit("miso line", 1'b1, sdaLine);
        misoData = 1'b0;
        cyc(2);
        check_bit("miso low", 1'b0, sdaLine);
        run_burst(4);
        check_nib("sclk rises", 4'h4, riseSeen[3:0]);
        check_nib("sclk falls", 4'h4, fallSeen[3:0]);
        host_pin_model_inst.spiCs_b = 1'b1;
        cyc(4);
        check_bit("miso released", 1'b0, sdOe);
        check_bit("chip select off", 1'b1, spiSelect_b);
        host_pin_model_inst.hostIfSelect = 1'b0;
        cyc(8);
        check_bit("mode kept", 1'b1, spiMode);
    endtask

    task automatic i2c_scenario(input strap_code_e t0, t1);
        host_pin_model_inst.tie[0] = t0;
        host_pin_model_inst.tie[1] = t1;
        enter_mode(1'b0);
        check_bit("select idle", 1'b1, spiSelect_b);
        check_bit("mosi idle", 1'b0, spiMosi);
        sdaDriveLow = 1'b1;
        cyc(2);
        check_bit("sda pulled low", 1'b0, sdaLine);
        sdaDriveLow = 1'b0;
        cyc(2);
        check_bit("sda released", 1'b0, sdOe);
        run_burst(6);
        check_nib("no sclk rises", 4'h0, riseSeen[3:0]);
        check_bit("scl level", sclPin, i2cScl);
        check_bit("sda level", sdaLine, i2cSdaIn);
        check_bit("address valid", 1'b1, aValid);
        check_nib("address code", {t1, t0}, aCode);
    endtask

    task automatic irq_scenario();
        irqPending = 1'b1;
        cyc(1);
        check_bit("irq asserted", 1'b1, irqOe);
        check_bit("irq drives low", 1'b0, irqOut);
        irqPending = 1'b0;
        cyc(1);
        check_bit("irq released", 1'b0, irqOe);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        wrap_up();
    end

    initial begin
        cyc(4);
        check_bit("reset select", 1'b1, spiSelect_b);
        check_bit("reset uart", 1'b1, uRst);
        rst_b = 1'b1;
        cyc(4);
        run_burst(2);
        check_bit("boot address valid", 1'b1, aValid);
        check_nib("boot address code", 4'h0, aCode);
        spi_scenario();
        i2c_scenario(STRAP_SCL, STRAP_SDA);
        i2c_scenario(STRAP_VL, STRAP_GND);
        irq_scenario();
        wrap_up();
    end
endmodule // host_port_pin_select_tb_top
